// ---- inc/asf_params.svh ----
// asf_params.svh: offsets, field positions, reset values, counts
// assumes: included by every design file of the status flag unit
// Overview of operation
// RULE1: the zero flag is set when an arithmetic or logical result is zero.
// RULE2: zero, overflow and carry are cleared when a capable op starts.
// RULE3: divide by zero returns the dividend and leaves zero clear.
// RULE4: overflow is set when a result leaves the range of its type.
// RULE5: overflow going from clear to set raises a minor fault; here an output bit op that sets overflow raises none.
// RULE6: a remainder overflow raises a minor fault, never the overflow flag.
// RULE7: carry is set on a carry out of the result's top bit.
// RULE8: the minor flag is set while at least one minor fault is present.
// RULE9: only programming faults drive the minor flag, never the battery.
// RULE10: every program scan clears the minor flag.
// RULE11: output_latch may set the minor flag on purpose.
// RULE12: flags are reached only through the examine and output bit ops.
// RULE13: a subscript expression updates flags and may raise minor faults.
// RULE14: a subscript that evaluates to zero may set the zero flag.
// RULE15: every flag holds until the next op able to change it.
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ASF_OFS_CTRL 8'h00
`define ASF_OFS_FLAGS 8'h04
`define ASF_OFS_RESULT 8'h08
`define ASF_OFS_FCNT 8'h0c
`define ASF_OFS_ISTAT 8'h10
`define ASF_OFS_IMASK 8'h14

// ----------------------------------------------------------------
// fields, reset values and widths
// ----------------------------------------------------------------
`define ASF_CTRL_EN_BIT 0
`define ASF_CTRL_EN_RST 1'h1
`define ASF_INT_MINOR_BIT 0
`define ASF_INT_BATT_BIT 1
`define ASF_INT_DIV0_BIT 2
`define ASF_INT_RST 3'h0
`define ASF_FCNT_MAX 16'hffff

`endif

// ---- inc/asf_pkg.sv ----
// asf_pkg.sv: types shared by the status flag unit files
// assumes: compiled before every design file
package asf_pkg;

    // arithmetic and logical operations of the executor
    typedef enum logic [2:0] {
        OP_ADD = 3'h0,
        OP_SUB = 3'h1,
        OP_MUL = 3'h2,
        OP_DIV = 3'h3,
        OP_MOD = 3'h4,
        OP_AND = 3'h5,
        OP_OR = 3'h6,
        OP_XOR = 3'h7
    } alu_op_t;

    // integer types: signed_byte_type, word, double word
    typedef enum logic [1:0] {
        DT_BYTE = 2'h0,
        DT_WORD = 2'h1,
        DT_DWORD = 2'h2
    } dtype_t;

    // bit instructions allowed to touch the flags
    typedef enum logic [2:0] {
        BIT_EXAMINE_IF_CLOSED = 3'h0,
        BIT_EXAMINE_IF_OPEN = 3'h1,
        BIT_OUTPUT_ENERGIZE = 3'h2,
        BIT_OUTPUT_LATCH = 3'h3,
        BIT_OUTPUT_UNLATCH = 3'h4
    } bit_op_t;

    typedef enum logic [1:0] {
        SEL_ZERO = 2'h0,
        SEL_OVF = 2'h1,
        SEL_CARRY = 2'h2,
        SEL_MINOR = 2'h3
    } flag_sel_t;

    typedef struct packed {
        logic minor;
        logic carry;
        logic ovf;
        logic zero;
    } flags_t;

    typedef struct packed {
        alu_op_t op;
        dtype_t dtype;
        logic [31:0] a;
        logic [31:0] b;
    } alu_in_t;

    typedef struct packed {
        logic [31:0] result;
        logic zero;
        logic ovf;
        logic carry;
        logic mod_flt;
        logic div0;
    } alu_out_t;

endpackage : asf_pkg

// ---- core/int_alu_core.sv ----
// int_alu_core.sv: combinational integer datapath with raw flags
// assumes: operands arrive as 32-bit words, type chosen per op
`timescale 1ns/100ps
`include "asf_params.svh"
module int_alu_core
    import asf_pkg::*;
(
    // operation request
    input wire alu_in_t in_i,
    // computed answer
    output alu_out_t out_o
);

    // sign-extend the low bits of a word for the selected type
    function automatic logic signed [63:0] sext(
        input logic [31:0] x, input dtype_t dt);
        logic signed [63:0] r;
        case (dt)
            DT_BYTE: r = {{56{x[7]}}, x[7:0]};
            DT_WORD: r = {{48{x[15]}}, x[15:0]};
            default: r = {{32{x[31]}}, x};
        endcase
        return r;
    endfunction : sext

    // zero-extend for the unsigned carry path
    function automatic logic [32:0] zext(
        input logic [31:0] x, input dtype_t dt);
        logic [32:0] r;
        case (dt)
            DT_BYTE: r = {25'h000_0000, x[7:0]};
            DT_WORD: r = {17'h0_0000, x[15:0]};
            default: r = {1'b0, x};
        endcase
        return r;
    endfunction : zext

    // carry out sits just above the type's top bit
    function automatic logic cbit(input logic [32:0] s, input dtype_t dt);
        logic r;
        case (dt)
            DT_BYTE: r = s[8];
            DT_WORD: r = s[16];
            default: r = s[32];
        endcase
        return r;
    endfunction : cbit

    logic signed [63:0] sa, sb, wide, quo, fit;
    logic [32:0] usum;
    logic div0;

    // one pass: wide result, then range check against the type
    always_comb
    begin
        out_o = '0;
        sa = sext(in_i.a, in_i.dtype);
        sb = sext(in_i.b, in_i.dtype);
        div0 = (sb == '0);
        quo = div0 ? sa : sa / sb; // divider never sees a zero
        usum = '0;
        case (in_i.op)
            OP_ADD: wide = sa + sb;
            OP_SUB: wide = sa - sb;
            OP_MUL: wide = sa * sb;
            OP_DIV: wide = quo; // RULE3
            OP_MOD: wide = div0 ? sa : sa - quo * sb;
            OP_AND: wide = sa & sb;
            OP_OR: wide = sa | sb;
            default: wide = sa ^ sb;
        endcase
        // subtract as a + ~b + 1, so carry is set when no borrow occurs
        if (in_i.op == OP_ADD)
            usum = zext(in_i.a, in_i.dtype) + zext(in_i.b, in_i.dtype);
        else if (in_i.op == OP_SUB)
            usum = zext(in_i.a, in_i.dtype) + zext(~in_i.b, in_i.dtype)
                + 33'h0_0000_0001;
        out_o.carry = (in_i.op == OP_ADD || in_i.op == OP_SUB)
            && cbit(usum, in_i.dtype); // RULE7
        fit = sext(wide[31:0], in_i.dtype);
        out_o.result = fit[31:0];
        out_o.ovf = (in_i.op != OP_MOD) && (wide != fit); // RULE4
        out_o.mod_flt = (in_i.op == OP_MOD)
            && (quo != sext(quo[31:0], in_i.dtype)); // RULE6
        out_o.div0 = (in_i.op == OP_DIV) && div0;
        out_o.zero = (fit == '0) && !out_o.div0; // RULE1 RULE3
    end

endmodule : int_alu_core

// ---- core/arith_status_flag_unit.sv ----
// arith_status_flag_unit.sv: zero, overflow, carry and minor flags
// assumes: executor logic on ref_clk_i issues at most one op a cycle;
// battery_low_i is an asynchronous pin
`timescale 1ns/100ps
`include "asf_params.svh"
module arith_status_flag_unit
    import asf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // arithmetic instruction
    input wire logic instr_valid_i,
    input wire alu_in_t instr_i,
    output logic done_o,
    output logic [31:0] result_o,
    // array subscript expression
    input wire logic sub_valid_i,
    input wire logic [31:0] sub_value_i,
    input wire logic sub_ovf_i,
    // scan and bit instructions
    input wire logic scan_start_i,
    input wire logic bit_valid_i,
    input wire bit_op_t bit_op_i,
    input wire flag_sel_t bit_sel_i,
    input wire logic rung_in_i,
    output logic bit_done_o,
    output logic rung_out_o,
    // flags and system
    input wire logic battery_low_i,
    output flags_t flags_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // state and wires
    // ----------------------------------------------------------------
    flags_t flags_ff, nxt_flags;
    alu_out_t alu_out;
    logic ctrl_en_ff;
    logic [31:0] result_ff, rdata_ff;
    logic done_ff, bit_done_ff, rung_ff, irq_ff;
    logic [15:0] fcnt_ff;
    logic [2:0] istat_ff, imask_ff, int_ev;
    logic bat_meta_ff, bat_sync_ff, bat_prev_ff;
    logic acc, sub_take, arith, arith_ovf, fault_raise;
    logic bit_wr, bit_val, cur_flag, sub_zero;

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    int_alu_core u_alu (
        .in_i (instr_i),
        .out_o (alu_out)
    );

    // disabled unit ignores executor requests entirely
    assign acc = instr_valid_i & ctrl_en_ff;
    assign sub_take = sub_valid_i & ctrl_en_ff; // RULE13
    assign arith = acc | sub_take;
    assign sub_zero = (sub_value_i == 32'h0000_0000);
    // both the expression and the instruction may overflow
    assign arith_ovf = (acc & alu_out.ovf) | (sub_take & sub_ovf_i);
    // flags were cleared first, so any overflow here is a rising one
    assign fault_raise = arith_ovf // RULE5
        | (acc & alu_out.mod_flt); // RULE6

    // result register, loaded only by an accepted instruction
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            result_ff <= 32'h0000_0000;
        else if (acc)
            result_ff <= alu_out.result; // RULE3
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            done_ff <= 1'b0;
        else
            done_ff <= acc;
    end

    // ----------------------------------------------------------------
    // bit instruction access
    // ----------------------------------------------------------------
    // only examine and output ops see the flags at all
    always_comb
    begin
        bit_wr = 1'b0;
        bit_val = 1'b0;
        if (bit_valid_i)
        begin
            case (bit_op_i)
                BIT_OUTPUT_ENERGIZE:
                begin
                    bit_wr = 1'b1; // RULE12
                    bit_val = rung_in_i;
                end
                BIT_OUTPUT_LATCH:
                begin
                    bit_wr = rung_in_i; // RULE11
                    bit_val = 1'b1;
                end
                BIT_OUTPUT_UNLATCH:
                begin
                    bit_wr = rung_in_i;
                    bit_val = 1'b0;
                end
                default:
                begin
                    bit_wr = 1'b0;
                    bit_val = 1'b0;
                end
            endcase
        end
    end

    // flag picked by the bit instruction
    always_comb
    begin
        case (bit_sel_i)
            SEL_ZERO: cur_flag = flags_ff.zero;
            SEL_OVF: cur_flag = flags_ff.ovf;
            SEL_CARRY: cur_flag = flags_ff.carry;
            default: cur_flag = flags_ff.minor;
        endcase
    end

    // rung result: examine ops gate, output ops pass the rung through
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            rung_ff <= 1'b0;
        else if (bit_valid_i && bit_op_i == BIT_EXAMINE_IF_CLOSED)
            rung_ff <= rung_in_i & cur_flag; // RULE12
        else if (bit_valid_i && bit_op_i == BIT_EXAMINE_IF_OPEN)
            rung_ff <= rung_in_i & ~cur_flag; // RULE12
        else if (bit_valid_i)
            rung_ff <= rung_in_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            bit_done_ff <= 1'b0;
        else
            bit_done_ff <= bit_valid_i;
    end

    // ----------------------------------------------------------------
    // flag update
    // ----------------------------------------------------------------
    // arithmetic beats a bit write to zero, overflow or carry;
    // a fault beats any clear of the minor flag
    always_comb
    begin
        nxt_flags = flags_ff; // RULE15
        if (arith)
        begin
            // computed fresh, nothing of the old values kept
            nxt_flags.zero = (acc & alu_out.zero) // RULE1 RULE2
                | (sub_take & sub_zero); // RULE14
            nxt_flags.ovf = arith_ovf; // RULE2 RULE4
            nxt_flags.carry = acc & alu_out.carry; // RULE2 RULE7
        end
        else if (bit_wr && bit_sel_i == SEL_ZERO)
            nxt_flags.zero = bit_val;
        else if (bit_wr && bit_sel_i == SEL_OVF)
            nxt_flags.ovf = bit_val;
        else if (bit_wr && bit_sel_i == SEL_CARRY)
            nxt_flags.carry = bit_val;
        // battery state never reaches this term
        if (fault_raise)
            nxt_flags.minor = 1'b1; // RULE8 RULE9
        else if (bit_wr && bit_sel_i == SEL_MINOR)
            nxt_flags.minor = bit_val; // RULE11
        else if (scan_start_i)
            nxt_flags.minor = 1'b0; // RULE10
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            flags_ff <= '0;
        else
            flags_ff <= nxt_flags;
    end

    // saturating count of raised minor faults
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            fcnt_ff <= 16'h0000;
        else if (fault_raise && fcnt_ff != `ASF_FCNT_MAX)
            fcnt_ff <= fcnt_ff + 16'h0001;
    end

    // ----------------------------------------------------------------
    // battery pin and interrupts
    // ----------------------------------------------------------------
    // two stages before any logic reads the pin
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            bat_meta_ff <= 1'b0;
            bat_sync_ff <= 1'b0;
            bat_prev_ff <= 1'b0;
        end
        else
        begin
            bat_meta_ff <= battery_low_i;
            bat_sync_ff <= bat_meta_ff;
            bat_prev_ff <= bat_sync_ff;
        end
    end

    // battery goes to the interrupt status and the FLAGS read bit, not the minor flag
    always_comb
    begin
        int_ev = 3'h0;
        int_ev[`ASF_INT_MINOR_BIT] = fault_raise;
        int_ev[`ASF_INT_BATT_BIT] = bat_sync_ff & ~bat_prev_ff; // RULE9
        int_ev[`ASF_INT_DIV0_BIT] = acc & alu_out.div0;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            istat_ff <= `ASF_INT_RST;
        else if (reg_wr_i && reg_addr_i == `ASF_OFS_ISTAT)
            istat_ff <= (istat_ff & ~reg_wdata_i[2:0]) | int_ev;
        else
            istat_ff <= istat_ff | int_ev;
    end

    // irq lags the status bit by one cycle, kept a plain flop
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(istat_ff & imask_ff);
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_en_ff <= `ASF_CTRL_EN_RST;
            imask_ff <= `ASF_INT_RST;
        end
        else if (reg_wr_i && reg_addr_i == `ASF_OFS_CTRL)
            ctrl_en_ff <= reg_wdata_i[`ASF_CTRL_EN_BIT];
        else if (reg_wr_i && reg_addr_i == `ASF_OFS_IMASK)
            imask_ff <= reg_wdata_i[2:0];
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            rdata_ff <= 32'h0000_0000;
        else if (!reg_rd_i)
            rdata_ff <= 32'h0000_0000;
        else if (reg_addr_i == `ASF_OFS_CTRL)
            rdata_ff <= {31'h0000_0000, ctrl_en_ff};
        else if (reg_addr_i == `ASF_OFS_FLAGS)
            rdata_ff <= {27'h000_0000, bat_sync_ff, flags_ff};
        else if (reg_addr_i == `ASF_OFS_RESULT)
            rdata_ff <= result_ff;
        else if (reg_addr_i == `ASF_OFS_FCNT)
            rdata_ff <= {16'h0000, fcnt_ff};
        else if (reg_addr_i == `ASF_OFS_ISTAT)
            rdata_ff <= {29'h0000_0000, istat_ff};
        else if (reg_addr_i == `ASF_OFS_IMASK)
            rdata_ff <= {29'h0000_0000, imask_ff};
        else
            rdata_ff <= 32'h0000_0000; // unmapped reads zero
    end

    assign reg_rdata_o = rdata_ff;
    assign result_o = result_ff;
    assign done_o = done_ff;
    assign flags_o = flags_ff;
    assign bit_done_o = bit_done_ff;
    assign rung_out_o = rung_ff;
    assign irq_o = irq_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_zero_on_result: // RULE1
    assert property (acc && alu_out.zero |=> flags_o.zero)
    else $error("zero flag missed a zero result");

    a_flags_cleared: // RULE2
    assert property (acc && !sub_take && !alu_out.zero && !alu_out.ovf
        && !alu_out.carry |=> !flags_o.zero && !flags_o.ovf
        && !flags_o.carry)
    else $error("stale flag survived a new instruction");

    a_div_by_zero: // RULE3
    assert property (acc && !sub_take && instr_i.op == OP_DIV
        && instr_i.dtype == DT_DWORD && instr_i.b == 32'h0000_0000
        |=> !flags_o.zero && result_o == $past(instr_i.a))
    else $error("divide by zero mishandled");

    a_ovf_sets_flag: // RULE4
    assert property (acc && alu_out.ovf |=> flags_o.ovf && done_o)
    else $error("overflow flag not set");

    a_ovf_raises_minor: // RULE5
    assert property ($rose(flags_o.ovf) && $past(arith)
        |-> flags_o.minor && istat_ff[`ASF_INT_MINOR_BIT])
    else $error("overflow rise without minor fault");

    a_mod_fault_only: // RULE6
    assert property (acc && !sub_take && alu_out.mod_flt
        |=> flags_o.minor && !flags_o.ovf)
    else $error("remainder overflow handled wrongly");

    a_carry_out: // RULE7
    assert property (acc && alu_out.carry |=> flags_o.carry)
    else $error("carry flag missed");

    a_minor_holds: // RULE8
    assert property (flags_o.minor && !scan_start_i && !bit_wr
        |=> flags_o.minor)
    else $error("minor flag dropped without a clear");

    a_battery_isolated: // RULE9
    assert property (!flags_o.minor && !fault_raise && !bit_wr
        |=> !flags_o.minor)
    else $error("minor flag set by a non-program cause");

    a_scan_clears: // RULE10
    assert property (scan_start_i && !fault_raise && !bit_wr
        |=> !flags_o.minor)
    else $error("scan start did not clear minor flag");

    a_latch_minor: // RULE11
    assert property (bit_valid_i && bit_op_i == BIT_OUTPUT_LATCH
        && bit_sel_i == SEL_MINOR && rung_in_i
        |=> flags_o.minor && bit_done_o)
    else $error("latch failed to set minor flag");

    a_subscript_zero: // RULE14
    assert property (sub_take && sub_zero |=> flags_o.zero)
    else $error("zero subscript did not set zero flag");

    a_flags_hold: // RULE15
    assert property (!arith && !bit_wr && !scan_start_i
        |=> $stable(flags_o))
    else $error("flags changed with no capable op");

endmodule : arith_status_flag_unit

// ---- verif/testbench.sv ----
// testbench.sv: self-checking bench of the arithmetic status flag unit
// assumes: asf_pkg compiled first, asf_params.svh on the include path
`timescale 1ns/100ps
`include "asf_params.svh"
module testbench
    import asf_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus, observed outputs, expectation queues
    // ------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic instr_valid_i = 1'b0;
    alu_in_t instr_i = '0;
    logic sub_valid_i = 1'b0;
    logic [31:0] sub_value_i = 32'h0000_0000;
    logic sub_ovf_i = 1'b0;
    logic scan_start_i = 1'b0;
    logic bit_valid_i = 1'b0;
    bit_op_t bit_op_i = BIT_EXAMINE_IF_CLOSED;
    flag_sel_t bit_sel_i = SEL_ZERO;
    logic rung_in_i = 1'b0;
    logic battery_low_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic done_o;
    logic [31:0] result_o;
    logic bit_done_o;
    logic rung_out_o;
    flags_t flags_o;
    logic irq_o;
    int err_total = 0;
    int cmp_count = 0;
    logic taken = 1'b1;
    logic rd_seen = 1'b0;
    logic [31:0] res_q[$];
    logic [31:0] rd_q[$];
    logic [3:0] fl_q[$];
    logic [3:0] bfl_q[$];
    logic rung_q[$];

    arith_status_flag_unit dut_u (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .done_o(done_o), .result_o(result_o),
        .sub_valid_i(sub_valid_i), .sub_value_i(sub_value_i),
        .sub_ovf_i(sub_ovf_i), .scan_start_i(scan_start_i),
        .bit_valid_i(bit_valid_i), .bit_op_i(bit_op_i),
        .bit_sel_i(bit_sel_i), .rung_in_i(rung_in_i),
        .bit_done_o(bit_done_o), .rung_out_o(rung_out_o),
        .battery_low_i(battery_low_i), .flags_o(flags_o), .irq_o(irq_o)
    );

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_flags(input flags_t got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t: flags %b want %b", $time, got, exp);
        end
    endtask : cmp_flags

    task automatic results;
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic pause(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : pause

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= adr;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [31:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= adr;
        rd_q.push_back(e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd

    // sub: bit1 subscript present, bit0 overflowed and nonzero
    task automatic alu(input alu_op_t op, input dtype_t dt,
        input logic [31:0] a, input logic [31:0] b, input logic [1:0] sub,
        input logic [31:0] res, input logic [3:0] fl);
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= '{op: op, dtype: dt, a: a, b: b};
        sub_valid_i <= sub[1];
        sub_ovf_i <= sub[0];
        sub_value_i <= {31'h0000_0000, sub[0]};
        if (taken)
        begin
            res_q.push_back(res);
            fl_q.push_back(fl);
        end
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        sub_valid_i <= 1'b0;
    endtask : alu

    task automatic bop(input bit_op_t op, input flag_sel_t sel,
        input logic rin, input logic rung, input logic [3:0] fl);
        @(posedge ref_clk_i);
        bit_valid_i <= 1'b1;
        bit_op_i <= op;
        bit_sel_i <= sel;
        rung_in_i <= rin;
        rung_q.push_back(rung);
        bfl_q.push_back(fl);
        @(posedge ref_clk_i);
        bit_valid_i <= 1'b0;
    endtask : bop

    task automatic scan;
        @(posedge ref_clk_i);
        scan_start_i <= 1'b1;
        @(posedge ref_clk_i);
        scan_start_i <= 1'b0;
    endtask : scan

    // irq is a registered level, so let the status settle first
    task automatic irq_is(input logic e);
        pause(3);
        #1;
        cmp_val({31'h0000_0000, irq_o}, {31'h0000_0000, e});
    endtask : irq_is

    function automatic logic [31:0] nxt_lfsr(input logic [31:0] s);
        nxt_lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt_lfsr

    // ------------------------------------------------------------
    // clock, watchdog and output monitor
    // ------------------------------------------------------------
    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // the sequence needs well under a thousand cycles
    initial
    begin
        pause(3000);
        err_total++;
        results();
    end

    // an unexpected done counts as a mismatch
    always @(posedge ref_clk_i)
    begin
        if (done_o === 1'b1 && res_q.size() == 0)
            cmp_val({31'h0000_0000, done_o}, 32'h0000_0000);
        else if (done_o === 1'b1)
        begin
            cmp_val(result_o, res_q.pop_front());
            cmp_flags(flags_o, fl_q.pop_front());
        end
        if (bit_done_o === 1'b1 && rung_q.size() != 0)
        begin
            cmp_val({31'h0000_0000, rung_out_o}, {31'h0, rung_q.pop_front()});
            cmp_flags(flags_o, bfl_q.pop_front());
        end
        if (rd_seen)
            cmp_val(reg_rdata_o, rd_q.pop_front());
        rd_seen <= reg_rd_i;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] r;
        logic [31:0] lfsr;
        alu_op_t op;
        lfsr = 32'h0000_43dc;
        pause(2);
        rst_b_i <= 1'b1;
        rd(`ASF_OFS_CTRL, 32'h0000_0001);
        rd(`ASF_OFS_IMASK, 32'h0000_0000);
        rd(`ASF_OFS_FLAGS, 32'h0000_0000);
        wr(`ASF_OFS_IMASK, 32'h0000_0001);
        alu(OP_ADD, DT_BYTE, 32'h7f, 32'h1, 2'h0, 32'hffff_ff80, 4'ha);
        rd(`ASF_OFS_ISTAT, 32'h0000_0001);
        irq_is(1'b1);
        wr(`ASF_OFS_ISTAT, 32'h0000_0001);
        irq_is(1'b0);
        alu(OP_ADD, DT_BYTE, 32'hff, 32'h1, 2'h0, 32'h0000_0000, 4'hd);
        scan();
        bop(BIT_EXAMINE_IF_CLOSED, SEL_ZERO, 1'b1, 1'b1, 4'h5);
        bop(BIT_EXAMINE_IF_OPEN, SEL_MINOR, 1'b1, 1'b1, 4'h5);
        bop(BIT_OUTPUT_LATCH, SEL_MINOR, 1'b0, 1'b0, 4'h5);
        bop(BIT_OUTPUT_LATCH, SEL_MINOR, 1'b1, 1'b1, 4'hd);
        bop(BIT_OUTPUT_UNLATCH, SEL_MINOR, 1'b1, 1'b1, 4'h5);
        bop(BIT_OUTPUT_ENERGIZE, SEL_CARRY, 1'b0, 1'b0, 4'h1);
        bop(BIT_OUTPUT_LATCH, SEL_OVF, 1'b1, 1'b1, 4'h3);
        alu(OP_DIV, DT_DWORD, 32'h5, 32'h0, 2'h0, 32'h0000_0005, 4'h0);
        rd(`ASF_OFS_ISTAT, 32'h0000_0004);
        alu(OP_DIV, DT_DWORD, 32'h0, 32'h3, 2'h0, 32'h0000_0000, 4'h1);
        alu(OP_MOD, DT_DWORD, 32'h8000_0000, 32'hffff_ffff, 2'h0,
            32'h0000_0000, 4'h9);
        alu(OP_ADD, DT_DWORD, 32'h1, 32'h1, 2'h2, 32'h0000_0002, 4'h9);
        scan();
        alu(OP_ADD, DT_DWORD, 32'h2, 32'h3, 2'h3, 32'h0000_0005, 4'ha);
        alu(OP_SUB, DT_DWORD, 32'h2, 32'h1, 2'h0, 32'h0000_0001, 4'hc);
        alu(OP_MUL, DT_WORD, 32'h3, 32'h4, 2'h0, 32'h0000_000c, 4'h8);
        // random logic ops, the first one forced to a zero result
        for (int i = 0; i < 9; i++)
        begin
            lfsr = nxt_lfsr(lfsr);
            a = lfsr;
            lfsr = nxt_lfsr(lfsr);
            b = (i == 0) ? ~a : lfsr;
            op = (i % 3 == 0) ? OP_AND : (i % 3 == 1) ? OP_OR : OP_XOR;
            r = (op == OP_AND) ? a & b : (op == OP_OR) ? a | b : a ^ b;
            alu(op, DT_DWORD, a, b, 2'h0, r, {3'h4, r == 32'h0});
        end
        // disabled executor takes nothing and answers nothing
        wr(`ASF_OFS_CTRL, 32'h0000_0000);
        taken = 1'b0;
        alu(OP_ADD, DT_DWORD, 32'h1, 32'h2, 2'h0, 32'h0000_0003, 4'h8);
        taken = 1'b1;
        rd(`ASF_OFS_CTRL, 32'h0000_0000);
        wr(`ASF_OFS_CTRL, 32'h0000_0001);
        scan();
        alu(OP_ADD, DT_DWORD, 32'h0, 32'h0, 2'h0, 32'h0000_0000, 4'h1);
        wr(`ASF_OFS_ISTAT, 32'h0000_0007);
        @(posedge ref_clk_i);
        battery_low_i <= 1'b1;
        pause(5);
        rd(`ASF_OFS_FLAGS, 32'h0000_0011);
        rd(`ASF_OFS_ISTAT, 32'h0000_0002);
        irq_is(1'b0);
        wr(`ASF_OFS_IMASK, 32'h0000_0002);
        irq_is(1'b1);
        wr(`ASF_OFS_ISTAT, 32'h0000_0002);
        irq_is(1'b0);
        battery_low_i <= 1'b0;
        rd(`ASF_OFS_RESULT, 32'h0000_0000);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0000_0000);
        rd(`ASF_OFS_FCNT, 32'h0000_0003);
        pause(4);
        results();
    end
endmodule : testbench
